// ==== pkg/dsd_pkg.sv ====
/*
  Constants, types and decode functions shared by the data-space decoder.
  Assumes an 8-bit core clocked on the same clock as the decoder.
*/
package dsd_pkg;
  // ----------------------------------------
  // Data-space map
  // ----------------------------------------
  localparam logic [15:0] DSD_IO_LAST = 16'h003f;
  localparam logic [15:0] DSD_SRAM_FIRST = 16'h0040;
  localparam logic [15:0] DSD_SRAM_LAST = 16'h013f;
  localparam logic [15:0] DSD_DIRECT_LAST = 16'h00bf;
  localparam logic [15:0] DSD_LOCK_FIRST = 16'h3f00;
  localparam logic [15:0] DSD_CFG_FIRST = 16'h3f40;
  localparam logic [15:0] DSD_CAL_FIRST = 16'h3f80;
  localparam logic [15:0] DSD_ID_FIRST = 16'h3fc0;
  localparam logic [15:0] DSD_FLASH_FIRST = 16'h4000;
  localparam logic [15:0] DSD_FLASH_LAST = 16'h47ff;
  localparam logic [5:0] DSD_NVM_PAIR_LEN = 6'h02;
  localparam logic [5:0] DSD_ID_LEN = 6'h04;
  // ----------------------------------------
  // I/O space and RAM port
  // ----------------------------------------
  localparam logic [5:0] DSD_BITOP_LAST = 6'h1f;
  localparam logic [5:0] DSD_RAM_DATA_IO = 6'h1f;
  localparam logic [5:0] DSD_RAM_ADDR_IO = 6'h20;
  localparam logic [7:0] DSD_RAM_ADDR_RESET = 8'h00;
  // ----------------------------------------
  // Program store and timing
  // ----------------------------------------
  localparam int DSD_PC_W = 11;
  localparam logic [10:0] DSD_PC_RESET = 11'h000;
  localparam int DSD_PROG_WORDS = 2048;
  localparam int DSD_SRAM_BYTES = 256;
  localparam int DSD_ACCESS_CYCLES = 2;

  typedef enum logic [3:0] {
    OP_DIRECT_LOAD, OP_DIRECT_STORE, OP_INDIRECT_LOAD, OP_INDIRECT_STORE,
    OP_IO_IN, OP_IO_OUT, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_SKIP_IF_SET, OP_SKIP_IF_CLEAR
  } dsd_op_t;

  typedef enum logic [1:0] {PTR_PLAIN, PTR_POST_INC, PTR_PRE_DEC} dsd_ptr_mode_t;

  typedef enum logic [2:0] {
    RG_IO, RG_SRAM, RG_LOCK, RG_CFG, RG_CAL, RG_ID, RG_FLASH, RG_RSVD
  } dsd_region_t;

  function automatic dsd_region_t dsd_decode(input logic [15:0] a);
    if (a <= DSD_IO_LAST) return RG_IO;
    if (a >= DSD_SRAM_FIRST && a <= DSD_SRAM_LAST) return RG_SRAM;
    if (a >= DSD_LOCK_FIRST && a < DSD_LOCK_FIRST + 16'(DSD_NVM_PAIR_LEN)) return RG_LOCK;
    if (a >= DSD_CFG_FIRST && a < DSD_CFG_FIRST + 16'(DSD_NVM_PAIR_LEN)) return RG_CFG;
    if (a >= DSD_CAL_FIRST && a < DSD_CAL_FIRST + 16'(DSD_NVM_PAIR_LEN)) return RG_CAL;
    if (a >= DSD_ID_FIRST && a < DSD_ID_FIRST + 16'(DSD_ID_LEN)) return RG_ID;
    if (a >= DSD_FLASH_FIRST && a <= DSD_FLASH_LAST) return RG_FLASH;
    return RG_RSVD;
  endfunction

  // Virtual 0x40..0xff stay put, 0x100..0x13f fold onto 0x00..0x3f
  function automatic logic [7:0] dsd_virt_to_phys(input logic [15:0] a);
    logic [15:0] p;
    p = (a >= 16'h0100) ? 16'(a - 16'h0100) : a;
    return p[7:0];
  endfunction
endpackage

// ==== logic/dsd_sram.sv ====
/*
  256-byte data SRAM of the decoder, addressed by physical byte address.
  Assumes one access per cycle; read is combinational, write on the clock edge.
*/
`timescale 1ns/1ps
module dsd_sram (
  // Clock
  input wire logic clk,
  // Access
  input wire logic [7:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:dsd_pkg::DSD_SRAM_BYTES-1];

  assign rdata = mem[addr];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule // dsd_sram

// ==== logic/dsd_ptr.sv ====
/*
  Three 16-bit pointer registers (general registers 26 to 31) used by
  indirect accesses, with post-increment and pre-decrement stepping.
  Assumes the core loads a pointer and steps it in different cycles.
*/
`timescale 1ns/1ps
module dsd_ptr (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Load from the core
  input wire logic ld_en,
  input wire logic [1:0] ld_sel,
  input wire logic [15:0] ld_val,
  // Step on an indirect access
  input wire logic step_en,
  input wire logic [1:0] sel,
  input wire dsd_pkg::dsd_ptr_mode_t mode,
  output logic [15:0] eff_addr,
  // Pointer values
  output logic [15:0] ptr_x,
  output logic [15:0] ptr_y,
  output logic [15:0] ptr_z
);
  logic [15:0] cur;
  logic [15:0] stepped;

  always_comb begin
    unique case (sel)
      2'h1: cur = ptr_y;
      2'h2: cur = ptr_z;
      default: cur = ptr_x;
    endcase
    stepped = (mode == dsd_pkg::PTR_PRE_DEC) ? 16'(cur - 16'h0001) : 16'(cur + 16'h0001);
    eff_addr = (mode == dsd_pkg::PTR_PRE_DEC) ? stepped : cur;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_x <= 16'h0000;
      ptr_y <= 16'h0000;
      ptr_z <= 16'h0000;
    end else if (ld_en) begin
      unique case (ld_sel)
        2'h1: ptr_y <= ld_val;
        2'h2: ptr_z <= ld_val;
        default: ptr_x <= ld_val;
      endcase
    end else if (step_en && mode != dsd_pkg::PTR_PLAIN) begin
      unique case (sel)
        2'h1: ptr_y <= stepped;
        2'h2: ptr_z <= stepped;
        default: ptr_x <= stepped;
      endcase
    end
  end
endmodule // dsd_ptr

// ==== logic/dsd_top.sv ====
/*
  Data-space decoder with indirect RAM port: decodes core accesses onto
  I/O space, data SRAM, read-only NVM bytes and the flash window.
  Assumes the core, peripherals, NVM bytes and flash read on clk.
*/
`timescale 1ns/1ps
// How it works
// RULE1: Program store is 2048 words of 16 bits; 11-bit counter resets to zero.
// RULE2: Data addresses 0x4000 to 0x47FF read program flash bytes.
// RULE3: Stores into the flash window change nothing.
// RULE4: The first 64 data addresses go to I/O space, not SRAM.
// RULE5: Data addresses 0x0040 to 0x013F select the 256-byte SRAM.
// RULE6: Lock, configuration and calibration bytes sit at fixed data addresses.
// RULE7: Lock, configuration, calibration, identity and flash bytes are read only.
// RULE8: A SRAM access from the core takes two clock cycles.
// RULE9: Direct load and store reach only 0x0040 to 0x00BF.
// RULE10: I/O in and out use I/O addresses 0x00 to 0x3F.
// RULE11: Indirect access reaches all data space; pre-decrement and post-increment update pointer.
// RULE12: Registers 26 to 31 form the three 16-bit pointers.
// RULE13: Virtual 0x40-0xFF map unchanged; 0x100-0x13F map to physical 0x00-0x3F.
// RULE14: RAM port uses its address register as physical address, no remap.
// RULE15: Writing the RAM port data register stores the byte at once.
// RULE16: Reading the RAM port data register returns the addressed byte at once.
// RULE17: Software loads the port address before using the port data register.
// RULE18: Bit set, clear and skip work on I/O 0x00 to 0x1F only.
// RULE19: Bit set and clear change only the targeted bit.
// RULE20: Software writes reserved bits as zero and avoids reserved I/O addresses.
// RULE21: Port address covers physical bytes 0 to 255 linearly.
// RULE22: Reserved data addresses alter nothing and read as zero.
module dsd_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core request
  input wire logic req_valid,
  output logic req_ready,
  input wire dsd_pkg::dsd_op_t req_op,
  input wire logic [15:0] req_addr,
  input wire logic [5:0] req_io_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [2:0] req_bit,
  input wire logic [1:0] req_ptr_sel,
  input wire dsd_pkg::dsd_ptr_mode_t req_ptr_mode,
  // Core answer
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_skip,
  output logic rsp_error,
  // Pointer load from the core
  input wire logic ptr_load,
  input wire logic [1:0] ptr_load_sel,
  input wire logic [15:0] ptr_load_val,
  output logic [15:0] ptr_x,
  output logic [15:0] ptr_y,
  output logic [15:0] ptr_z,
  // Program counter
  input wire logic pc_step,
  input wire logic pc_load,
  input wire logic [10:0] pc_load_val,
  output logic [10:0] program_counter,
  // Flash read window
  output logic [9:0] flash_word_addr,
  input wire logic [15:0] flash_word,
  // Non-volatile bytes
  input wire logic [15:0] nvm_lock_bytes,
  input wire logic [15:0] nvm_config_bytes,
  input wire logic [15:0] nvm_calib_bytes,
  input wire logic [31:0] nvm_ident_bytes,
  // Peripheral I/O space
  output logic io_we,
  output logic io_re,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic [7:0] io_wmask,
  input wire logic [7:0] io_rdata
);
  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic accept;
  logic [15:0] ptr_ea;
  logic [15:0] ea;
  logic is_write;
  logic is_bitop;
  logic is_indirect;
  logic [7:0] bit_mask;
  logic [7:0] wdata_in;
  logic refused;
  dsd_pkg::dsd_region_t region;
  logic io_internal;

  assign accept = req_valid && req_ready;
  assign bit_mask = 8'(8'h01 << req_bit);
  assign is_indirect = req_op == dsd_pkg::OP_INDIRECT_LOAD || req_op == dsd_pkg::OP_INDIRECT_STORE;
  assign is_bitop = req_op == dsd_pkg::OP_IO_BIT_SET || req_op == dsd_pkg::OP_IO_BIT_CLEAR
    || req_op == dsd_pkg::OP_SKIP_IF_SET || req_op == dsd_pkg::OP_SKIP_IF_CLEAR;
  assign is_write = req_op == dsd_pkg::OP_DIRECT_STORE || req_op == dsd_pkg::OP_INDIRECT_STORE
    || req_op == dsd_pkg::OP_IO_OUT || req_op == dsd_pkg::OP_IO_BIT_SET
    || req_op == dsd_pkg::OP_IO_BIT_CLEAR;

  always_comb begin
    unique case (req_op)
      dsd_pkg::OP_DIRECT_LOAD, dsd_pkg::OP_DIRECT_STORE:
        ea = 16'(dsd_pkg::DSD_SRAM_FIRST + {9'h000, req_addr[6:0]}); // RULE9
      dsd_pkg::OP_INDIRECT_LOAD, dsd_pkg::OP_INDIRECT_STORE:
        ea = ptr_ea; // RULE11
      default:
        ea = {10'h000, req_io_addr}; // RULE10
    endcase
    unique case (req_op)
      dsd_pkg::OP_IO_BIT_SET: wdata_in = bit_mask;
      dsd_pkg::OP_IO_BIT_CLEAR: wdata_in = 8'h00;
      default: wdata_in = req_wdata;
    endcase
  end

  assign region = dsd_pkg::dsd_decode(ea); // RULE4 RULE5 RULE6
  assign io_internal = ea[5:0] == dsd_pkg::DSD_RAM_DATA_IO || ea[5:0] == dsd_pkg::DSD_RAM_ADDR_IO;
  assign refused = (is_bitop && req_io_addr > dsd_pkg::DSD_BITOP_LAST) // RULE18
    || (is_write && region != dsd_pkg::RG_IO && region != dsd_pkg::RG_SRAM); // RULE3 RULE7 RULE22

  // ----------------------------------------
  // Pointer file
  // ----------------------------------------
  dsd_ptr u_ptr (
    .clk(clk),
    .rst_n(rst_n),
    .ld_en(ptr_load),
    .ld_sel(ptr_load_sel),
    .ld_val(ptr_load_val),
    .step_en(accept && is_indirect), // RULE11 RULE12
    .sel(req_ptr_sel),
    .mode(req_ptr_mode),
    .eff_addr(ptr_ea),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .ptr_z(ptr_z)
  );

  // ----------------------------------------
  // Access stage (second cycle)
  // ----------------------------------------
  logic s1_valid;
  dsd_pkg::dsd_op_t s1_op;
  dsd_pkg::dsd_region_t s1_region;
  logic [15:0] s1_addr;
  logic [7:0] s1_wdata;
  logic [7:0] s1_mask;
  logic [2:0] s1_bit;
  logic s1_write;
  logic s1_refused;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_valid <= 1'b0;
      req_ready <= 1'b1;
      s1_op <= dsd_pkg::OP_DIRECT_LOAD;
      s1_region <= dsd_pkg::RG_RSVD;
      s1_addr <= 16'h0000;
      s1_wdata <= 8'h00;
      s1_mask <= 8'h00;
      s1_bit <= 3'h0;
      s1_write <= 1'b0;
      s1_refused <= 1'b0;
    end else begin
      s1_valid <= accept;
      req_ready <= !accept; // RULE8
      if (accept) begin
        s1_op <= req_op;
        s1_region <= region;
        s1_addr <= ea;
        s1_wdata <= wdata_in;
        s1_mask <= is_bitop ? bit_mask : 8'hff; // RULE19
        s1_bit <= req_bit;
        s1_write <= is_write;
        s1_refused <= refused;
      end
    end
  end

  // ----------------------------------------
  // Peripheral and flash strobes
  // ----------------------------------------
  logic io_go;
  assign io_go = accept && region == dsd_pkg::RG_IO && !io_internal && !refused;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_we <= 1'b0;
      io_re <= 1'b0;
      io_addr <= 6'h00;
      io_wdata <= 8'h00;
      io_wmask <= 8'h00;
    end else begin
      io_we <= io_go && is_write; // RULE4
      io_re <= io_go && !is_write;
      if (io_go) begin
        io_addr <= ea[5:0];
        io_wdata <= wdata_in;
        io_wmask <= is_bitop ? bit_mask : 8'hff; // RULE19
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_word_addr <= 10'h000;
    end else if (accept && region == dsd_pkg::RG_FLASH) begin
      flash_word_addr <= 10'(16'(ea - dsd_pkg::DSD_FLASH_FIRST) >> 1); // RULE2
    end
  end

  // ----------------------------------------
  // SRAM and RAM port
  // ----------------------------------------
  logic [7:0] ram_port_address_reg;
  logic port_data_hit;
  logic port_addr_hit;
  logic sram_we;
  logic [7:0] sram_addr;
  logic [7:0] sram_rdata;
  logic [7:0] sram_wdata;

  assign port_data_hit = s1_region == dsd_pkg::RG_IO && s1_addr[5:0] == dsd_pkg::DSD_RAM_DATA_IO;
  assign port_addr_hit = s1_region == dsd_pkg::RG_IO && s1_addr[5:0] == dsd_pkg::DSD_RAM_ADDR_IO;
  assign sram_addr = port_data_hit ? ram_port_address_reg // RULE14 RULE21
    : dsd_pkg::dsd_virt_to_phys(s1_addr); // RULE13
  assign sram_we = s1_valid && s1_write && !s1_refused
    && (s1_region == dsd_pkg::RG_SRAM || port_data_hit); // RULE15 RULE3
  assign sram_wdata = (sram_rdata & ~s1_mask) | (s1_wdata & s1_mask); // RULE19

  dsd_sram u_sram (
    .clk(clk),
    .addr(sram_addr),
    .we(sram_we),
    .wdata(sram_wdata),
    .rdata(sram_rdata)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_port_address_reg <= dsd_pkg::DSD_RAM_ADDR_RESET;
    end else if (s1_valid && s1_write && !s1_refused && port_addr_hit) begin
      ram_port_address_reg <= (ram_port_address_reg & ~s1_mask) | (s1_wdata & s1_mask);
    end
  end

  // ----------------------------------------
  // Read data and answer
  // ----------------------------------------
  logic [7:0] rd_byte;
  logic [3:0] nvm_sel;

  always_comb begin
    nvm_sel = {s1_addr[1:0], 2'h0};
    unique case (s1_region)
      dsd_pkg::RG_IO:
        rd_byte = port_data_hit ? sram_rdata // RULE16
          : port_addr_hit ? ram_port_address_reg : io_rdata;
      dsd_pkg::RG_SRAM: rd_byte = sram_rdata;
      dsd_pkg::RG_LOCK: rd_byte = s1_addr[0] ? nvm_lock_bytes[15:8] : nvm_lock_bytes[7:0];
      dsd_pkg::RG_CFG: rd_byte = s1_addr[0] ? nvm_config_bytes[15:8] : nvm_config_bytes[7:0];
      dsd_pkg::RG_CAL: rd_byte = s1_addr[0] ? nvm_calib_bytes[15:8] : nvm_calib_bytes[7:0];
      dsd_pkg::RG_ID: rd_byte = 8'(nvm_ident_bytes >> {nvm_sel, 1'b0});
      dsd_pkg::RG_FLASH: rd_byte = s1_addr[0] ? flash_word[15:8] : flash_word[7:0]; // RULE2
      default: rd_byte = 8'h00; // RULE22
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_skip <= 1'b0;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= s1_valid; // RULE8
      if (s1_valid) begin
        rsp_rdata <= (s1_write || s1_refused) ? 8'h00 : rd_byte;
        rsp_error <= s1_refused; // RULE18 RULE7
        unique case (s1_op)
          dsd_pkg::OP_SKIP_IF_SET: rsp_skip <= !s1_refused && rd_byte[s1_bit]; // RULE18
          dsd_pkg::OP_SKIP_IF_CLEAR: rsp_skip <= !s1_refused && !rd_byte[s1_bit];
          default: rsp_skip <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter <= dsd_pkg::DSD_PC_RESET; // RULE1
    end else if (pc_load) begin
      program_counter <= pc_load_val;
    end else if (pc_step) begin
      program_counter <= 11'(program_counter + 11'h001); // RULE1
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_sram_req;
    accept && region == dsd_pkg::RG_SRAM;
  endsequence
  sequence s_answer;
    !rsp_valid ##2 rsp_valid;
  endsequence

  a_sram_two_cycles: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    s_sram_req |-> s_answer ##0 !rsp_error)
    else $error("SRAM access did not answer in two cycles");

  a_flash_no_store: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    accept && is_write && region == dsd_pkg::RG_FLASH |-> ##1 !sram_we ##1 rsp_error)
    else $error("store to flash window was not refused");

  a_ro_no_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    s1_valid && s1_region inside {dsd_pkg::RG_LOCK, dsd_pkg::RG_CFG, dsd_pkg::RG_CAL,
      dsd_pkg::RG_ID, dsd_pkg::RG_RSVD} |-> !sram_we && !io_we)
    else $error("read-only region caused a write");

  a_direct_range: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    accept && req_op inside {dsd_pkg::OP_DIRECT_LOAD, dsd_pkg::OP_DIRECT_STORE}
      |-> ea >= 16'h0040 && ea <= 16'h00bf)
    else $error("direct access outside its window");

  a_remap_fold: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    s1_valid && s1_region == dsd_pkg::RG_SRAM && s1_addr >= 16'h0100
      |-> sram_addr == 8'(s1_addr - 16'h0100))
    else $error("high virtual SRAM address not folded");

  a_port_physical: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    s1_valid && port_data_hit |-> sram_addr == ram_port_address_reg)
    else $error("RAM port did not use its address register");

  a_port_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    accept && req_op == dsd_pkg::OP_IO_OUT && req_io_addr == 6'h1f
      |-> ##1 sram_we && sram_wdata == $past(req_wdata))
    else $error("RAM port data write not stored");

  a_bitop_range: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    accept && is_bitop && req_io_addr > 6'h1f |-> ##1 !io_we && !io_re ##1 rsp_error && !rsp_skip)
    else $error("bit operation above 0x1f not refused");

  a_bit_single: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    accept && req_op inside {dsd_pkg::OP_IO_BIT_SET, dsd_pkg::OP_IO_BIT_CLEAR} && io_go
      |=> io_we && $onehot(io_wmask))
    else $error("bit set or clear touched more than one bit");

  a_io_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    io_we || io_re |-> $past(ea) <= 16'h003f)
    else $error("I/O strobe outside the first 64 addresses");

  a_pc_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    pc_step && !pc_load |=> program_counter == 11'($past(program_counter) + 11'h001))
    else $error("program counter did not advance by one");

  a_ptr_postinc: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    accept && is_indirect && req_ptr_sel == 2'h0 && req_ptr_mode == dsd_pkg::PTR_POST_INC
      && !ptr_load |=> ptr_x == 16'($past(ptr_x) + 16'h0001))
    else $error("post-increment did not update pointer");
endmodule // dsd_top

// ==== sim/dsd_far_model.sv ====
/*
  Far side of the decoder: peripheral I/O bytes, flash words, NVM bytes.
  Assumes the decoder's clk and its one-cycle I/O strobes.
*/
`timescale 1ns/1ps
module dsd_far_model #(
  parameter logic [15:0] lock_val = 16'hc3b2,
  parameter logic [15:0] cfg_val = 16'h4e71,
  parameter logic [15:0] cal_val = 16'h9d08,
  // Arbitrary identity value
  parameter logic [31:0] id_val = 32'h1234_5678
) (
  // Clock
  input wire logic clk,
  // Peripheral access
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_wmask,
  output logic [7:0] io_rdata,
  // Flash and NVM bytes
  input wire logic [9:0] flash_word_addr,
  output logic [15:0] flash_word,
  output logic [15:0] nvm_lock_bytes,
  output logic [15:0] nvm_config_bytes,
  output logic [15:0] nvm_calib_bytes,
  output logic [31:0] nvm_ident_bytes
);
  logic [7:0] io_mem [64];
  initial begin
    foreach (io_mem[i]) io_mem[i] = 8'h00;
  end
  // Only masked bits change
  always @(posedge clk) begin
    if (io_we) io_mem[io_addr] <= (io_mem[io_addr] & ~io_wmask) | (io_wdata & io_wmask);
  end
  // Outside a read the inverse is shown, never the stale byte
  assign io_rdata = io_re ? io_mem[io_addr] : ~io_mem[io_addr];
  assign flash_word = {flash_word_addr[7:0] ^ 8'h5a, flash_word_addr[7:0]};
  assign nvm_lock_bytes = lock_val;
  assign nvm_config_bytes = cfg_val;
  assign nvm_calib_bytes = cal_val;
  assign nvm_ident_bytes = id_val;
endmodule // dsd_far_model

// ==== sim/tb_top.sv ====
/*
  Self-checking bench for the data-space decoder and its far-side model.
  Assumes dsd_pkg is compiled first; clock 50 MHz.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, rsp_valid, rsp_skip, rsp_error, io_we, io_re;
  dsd_pkg::dsd_op_t req_op = dsd_pkg::OP_DIRECT_LOAD;
  dsd_pkg::dsd_ptr_mode_t req_ptr_mode = dsd_pkg::PTR_PLAIN;
  logic [15:0] req_addr = 16'h0000;
  logic [5:0] req_io_addr = 6'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [2:0] req_bit = 3'h0;
  logic [1:0] req_ptr_sel = 2'h0;
  logic [7:0] rsp_rdata, io_wdata, io_wmask, io_rdata;
  logic ptr_load = 1'b0;
  logic [1:0] ptr_load_sel = 2'h0;
  logic [15:0] ptr_load_val = 16'h0000;
  logic [15:0] ptr_x, ptr_y, ptr_z, flash_word;
  logic [15:0] nvm_lock_bytes, nvm_config_bytes, nvm_calib_bytes;
  logic [31:0] nvm_ident_bytes;
  logic pc_step = 1'b0;
  logic pc_load = 1'b0;
  logic [10:0] pc_load_val = 11'h000;
  logic [10:0] program_counter;
  logic [9:0] flash_word_addr;
  logic [5:0] io_addr;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  dsd_top u_dsd_top (.clk, .rst_n, .req_valid, .req_ready, .req_op, .req_addr, .req_io_addr,
    .req_wdata, .req_bit, .req_ptr_sel, .req_ptr_mode, .rsp_valid, .rsp_rdata, .rsp_skip,
    .rsp_error, .ptr_load, .ptr_load_sel, .ptr_load_val, .ptr_x, .ptr_y, .ptr_z, .pc_step,
    .pc_load, .pc_load_val, .program_counter, .flash_word_addr, .flash_word, .nvm_lock_bytes,
    .nvm_config_bytes, .nvm_calib_bytes, .nvm_ident_bytes, .io_we, .io_re, .io_addr,
    .io_wdata, .io_wmask, .io_rdata);
  dsd_far_model u_dsd_far_model (.clk, .io_we, .io_re, .io_addr, .io_wdata, .io_wmask,
    .io_rdata, .flash_word_addr, .flash_word, .nvm_lock_bytes, .nvm_config_bytes,
    .nvm_calib_bytes, .nvm_ident_bytes);

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic req(input dsd_pkg::dsd_op_t op, input logic [15:0] a, input logic [7:0] d,
      input logic [2:0] b = 3'h0, input dsd_pkg::dsd_ptr_mode_t m = dsd_pkg::PTR_PLAIN);
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_io_addr <= a[5:0];
    req_wdata <= d;
    req_bit <= b;
    req_ptr_mode <= m;
    #1 `CHK("req_ready", 1'b1, req_ready)
    @(posedge clk);
    req_valid <= 1'b0;
    @(posedge clk);
    #1 `CHK("rsp_valid", 1'b1, rsp_valid)
  endtask
  task automatic ldp(input logic [1:0] s, input logic [15:0] v);
    @(posedge clk);
    ptr_load <= 1'b1;
    ptr_load_sel <= s;
    ptr_load_val <= v;
    req_ptr_sel <= s;
    @(posedge clk);
    ptr_load <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    ldp(2'h0, a);
    req(dsd_pkg::OP_INDIRECT_LOAD, 16'h0000, 8'h00);
    `CHK("rsp_rdata", e, rsp_rdata)
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic e);
    ldp(2'h0, a);
    req(dsd_pkg::OP_INDIRECT_STORE, 16'h0000, d);
    `CHK("rsp_error", e, rsp_error)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pc;
    `CHK("pc_reset", 11'h000, program_counter)
    @(posedge clk);
    pc_load <= 1'b1;
    pc_load_val <= 11'h7ff;
    @(posedge clk);
    pc_load <= 1'b0;
    pc_step <= 1'b1;
    @(posedge clk);
    pc_step <= 1'b0;
    #1 `CHK("pc_wrap", 11'h000, program_counter)
  endtask
  task automatic t_sram;
    wr(16'h0100, 8'ha5, 1'b0);
    req(dsd_pkg::OP_IO_OUT, 16'h0020, 8'h00);
    req(dsd_pkg::OP_IO_IN, 16'h001f, 8'h00);
    `CHK("port_rd", 8'ha5, rsp_rdata)
    req(dsd_pkg::OP_IO_OUT, 16'h0020, 8'hc0);
    req(dsd_pkg::OP_IO_OUT, 16'h001f, 8'h3c);
    rd(16'h00c0, 8'h3c);
    wr(16'h013f, 8'h11, 1'b0);
    req(dsd_pkg::OP_IO_OUT, 16'h0020, 8'h3f);
    req(dsd_pkg::OP_IO_IN, 16'h001f, 8'h00);
    `CHK("port_rd", 8'h11, rsp_rdata)
    req(dsd_pkg::OP_DIRECT_STORE, 16'h007f, 8'h66);
    req(dsd_pkg::OP_DIRECT_LOAD, 16'h00ff, 8'h00);
    `CHK("direct_rd", 8'h66, rsp_rdata)
    rd(16'h00bf, 8'h66);
  endtask
  task automatic t_ptr;
    ldp(2'h1, 16'h0041);
    req(dsd_pkg::OP_INDIRECT_STORE, 16'h0000, 8'h22, 3'h0, dsd_pkg::PTR_PRE_DEC);
    `CHK("ptr_y", 16'h0040, ptr_y)
    ldp(2'h2, 16'h00c8);
    req(dsd_pkg::OP_INDIRECT_LOAD, 16'h0000, 8'h00, 3'h0, dsd_pkg::PTR_POST_INC);
    `CHK("ptr_z", 16'h00c9, ptr_z)
    req(dsd_pkg::OP_DIRECT_LOAD, 16'h0000, 8'h00);
    `CHK("direct_rd", 8'h22, rsp_rdata)
    ldp(2'h0, 16'h0040);
    req(dsd_pkg::OP_INDIRECT_LOAD, 16'h0000, 8'h00, 3'h0, dsd_pkg::PTR_POST_INC);
    `CHK("ptr_x", 16'h0041, ptr_x)
    `CHK("post_inc_rd", 8'h22, rsp_rdata)
  endtask
  task automatic t_io;
    wr(16'h0005, 8'h81, 1'b0);
    req(dsd_pkg::OP_IO_BIT_SET, 16'h0005, 8'h00, 3'h2);
    req(dsd_pkg::OP_IO_BIT_CLEAR, 16'h0005, 8'h00, 3'h7);
    `CHK("io_wmask", 8'h80, io_wmask)
    req(dsd_pkg::OP_IO_IN, 16'h0005, 8'h00);
    `CHK("io_rd", 8'h05, rsp_rdata)
    req(dsd_pkg::OP_SKIP_IF_SET, 16'h0005, 8'h00, 3'h0);
    `CHK("skip", 1'b1, rsp_skip)
    req(dsd_pkg::OP_SKIP_IF_CLEAR, 16'h0005, 8'h00, 3'h0);
    `CHK("skip", 1'b0, rsp_skip)
    req(dsd_pkg::OP_IO_BIT_SET, 16'h0021, 8'h00, 3'h0);
    `CHK("bitop_err", 1'b1, rsp_error)
    req(dsd_pkg::OP_IO_OUT, 16'h003f, 8'h44);
    `CHK("io_addr", 6'h3f, io_addr)
    `CHK("io_wdata", 8'h44, io_wdata)
    rd(16'h003f, 8'h44);
  endtask
  task automatic t_ro;
    rd(16'h3f00, u_dsd_far_model.lock_val[7:0]);
    rd(16'h3f41, u_dsd_far_model.cfg_val[15:8]);
    rd(16'h3f81, u_dsd_far_model.cal_val[15:8]);
    rd(16'h3fc3, u_dsd_far_model.id_val[31:24]);
    wr(16'h3f00, 8'h00, 1'b1);
    rd(16'h4001, 8'h5a);
    rd(16'h47fe, 8'hff);
    `CHK("flash_addr", 10'h3ff, flash_word_addr)
    wr(16'h47ff, 8'h00, 1'b1);
    rd(16'h47ff, 8'ha5);
    rd(16'h3f02, 8'h00);
    wr(16'h0140, 8'h77, 1'b1);
    rd(16'h4800, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_pc();
    t_sram();
    t_ptr();
    t_io();
    t_ro();
    end_sim();
  end
endmodule // tb_top
